// >>> verilog/tc_params.svh
// Purpose: Constants for the two-channel thermostat with heating curve
// Assumes: 250 MHz system clock, one timing tick every 100 ms
// Notes:   Temperatures are signed whole degrees Celsius
`ifndef TC_PARAMS_SVH
`define TC_PARAMS_SVH

// Clock and base tick
`define TC_CLK_MHZ      250
`define TC_TICK_MS      100
`define TC_TICK_CYC     (`TC_TICK_MS * 1000 * `TC_CLK_MHZ)

// Display and button times in ms, converted to ticks
`define TC_ROT_MS       8000
`define TC_ROT_TICKS    (`TC_ROT_MS / `TC_TICK_MS)
`define TC_SHOW_MS      3000
`define TC_SHOW_TICKS   (`TC_SHOW_MS / `TC_TICK_MS)
`define TC_LONG_MS      5000
`define TC_LONG_TICKS   (`TC_LONG_MS / `TC_TICK_MS)
`define TC_SHORT_MS     1000
`define TC_SHORT_TICKS  (`TC_SHORT_MS / `TC_TICK_MS)
`define TC_BLINK_MS     500
`define TC_BLINK_TICKS  (`TC_BLINK_MS / `TC_TICK_MS)

// Curve hour length
`define TC_HOUR_S       3600
`define TC_HOUR_TICKS   (`TC_HOUR_S * 1000 / `TC_TICK_MS)

// Dial: code 0 is off, codes 1..31 give 20..50 degrees
`define TC_DIAL_OFF     5'h00
`define TC_DIAL_BASE    8'h13

// Regulation and sensor limits
`define TC_HYST         8'sh01
`define TC_FAULT_HI     8'sh50
`define TC_FAULT_LO     (-8'sh14)

`endif

// >>> verilog/tc_pkg.sv
// Purpose: Types for the two-channel thermostat
// Assumes: Constants come from tc_params.svh
// Notes:   All state records are packed structs
package tc_pkg;

  typedef logic signed [7:0] temp_t;

  // Per-channel operating state
  typedef enum logic [2:0] {
    CRV_NORMAL  = 3'b001,
    CRV_STOPPED = 3'b010,
    CRV_RUN     = 3'b100
  } curve_e;

  // What the display shows
  typedef enum logic [3:0] {
    DISP_ACTUAL = 4'b0001,
    DISP_SETPT  = 4'b0010,
    DISP_OFF    = 4'b0100,
    DISP_ERR    = 4'b1000
  } disp_e;

  // Regulator state of one channel
  typedef struct packed {
    temp_t s1;
    temp_t s2;
    temp_t s3;
    temp_t act;
    logic  fault;
    logic  relay;
  } reg_s;

  // Control state of one channel
  typedef struct packed {
    curve_e      crv;
    temp_t       sp;
    logic        capt;
    logic        pend;
    logic [4:0]  dial;
    logic [4:0]  idle;
    logic        btn;
    logic [5:0]  press;
    logic        long_done;
    logic [15:0] hr_ticks;
    logic [6:0]  hrs;
  } chan_s;

  // Whole controller state
  typedef struct packed {
    chan_s [1:0]      ch;
    logic [1:0][4:0]  dial_s1;
    logic [1:0][4:0]  dial_s2;
    logic [1:0][4:0]  dial_s3;
    logic [1:0]       btn_s1;
    logic [1:0]       btn_s2;
    logic [1:0]       btn_s3;
    logic [24:0]      tick_cnt;
    logic             tick;
    logic [2:0]       blink_cnt;
    logic             blink;
    logic [6:0]       rot_cnt;
    logic             rot;
    logic [4:0]       show_cnt;
    logic             show_ch;
    disp_e            kind;
    logic             disp_ch;
    temp_t            value;
    logic             dp;
    logic             green;
    logic [1:0]       red;
    logic [1:0]       chan_led;
    logic [1:0]       curve_mode;
  } state_s;

endpackage : tc_pkg

// >>> verilog/chan_reg.sv
// Purpose: On/off regulator for one channel with sensor check
// Assumes: Sensor word arrives from another domain as whole degrees
// Notes:   Relay drops at once on a sensor fault or when disabled
`timescale 1ns/1ps
`include "tc_params.svh"
module chan_reg (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  // Sensor and control
  input  wire tc_pkg::temp_t sensor_i,
  input  wire tc_pkg::temp_t setpt_i,
  input  wire logic          enable_i,
  // Results
  output logic               relay_o,
  output logic               fault_o,
  output tc_pkg::temp_t      actual_o
);

  tc_pkg::reg_s q;
  tc_pkg::reg_s d;

  // Sync, fault check and two-position control
  always_comb begin
    d    = q;
    d.s1 = sensor_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.act = q.s3;
    end
    d.fault = (q.act > `TC_FAULT_HI) || (q.act < `TC_FAULT_LO);
    if (!enable_i || d.fault) begin
      d.relay = 1'b0;
    end else if (q.act < tc_pkg::temp_t'(setpt_i - `TC_HYST)) begin
      d.relay = 1'b1;
    end else if (q.act > setpt_i) begin
      d.relay = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign relay_o  = q.relay;
  assign fault_o  = q.fault;
  assign actual_o = q.act;

endmodule : chan_reg

// >>> verilog/thermostat_ctrl.sv
// Purpose: Two-channel thermostat with dial setpoint and heating curve
// Assumes: Curve parameters are stable levels on the system clock
// Notes:   Timing runs from a 100 ms tick; shorten TICK_CYCLES to simulate
`timescale 1ns/1ps
`include "tc_params.svh"
module thermostat_ctrl #(
  parameter int unsigned TICK_CYCLES = `TC_TICK_CYC,
  parameter int unsigned HOUR_TICKS  = `TC_HOUR_TICKS
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  // Front panel
  input  wire logic                 first_channel_button_i,
  input  wire logic                 second_channel_button_i,
  input  wire logic [1:0][4:0]      dial_pos_i,
  // Sensors
  input  wire tc_pkg::temp_t [1:0]  sensor_temp_i,
  // Curve parameters
  input  wire tc_pkg::temp_t        curve_start_temp_i,
  input  wire tc_pkg::temp_t        curve_end_temp_i,
  input  wire logic [6:0]           hours_per_degree_i,
  // Relays and LEDs
  output logic [1:0]                relay_o,
  output logic [1:0]                red_led_o,
  output logic [1:0]                chan_led_o,
  output logic                      green_led_o,
  output logic [1:0]                curve_mode_o,
  // Display
  output tc_pkg::disp_e             disp_kind_o,
  output logic                      disp_chan_o,
  output tc_pkg::temp_t             disp_value_o,
  output logic                      disp_point_o
);

  tc_pkg::state_s      s_q;
  tc_pkg::state_s      s_d;
  logic [1:0]          reg_en;
  logic [1:0]          fault;
  tc_pkg::temp_t [1:0] actual;

  // Dial code to setpoint
  function automatic tc_pkg::temp_t dial_temp(input logic [4:0] code);
    dial_temp = tc_pkg::temp_t'({3'h0, code} + `TC_DIAL_BASE);
  endfunction : dial_temp

  // One regulator per channel
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign reg_en[g] = !(s_q.ch[g].crv == tc_pkg::CRV_NORMAL &&
                         s_q.ch[g].dial == `TC_DIAL_OFF);
    chan_reg u_reg (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .sensor_i  (sensor_temp_i[g]),
      .setpt_i   (s_q.ch[g].sp),
      .enable_i  (reg_en[g]),
      .relay_o   (relay_o[g]),
      .fault_o   (fault[g]),
      .actual_o  (actual[g])
    );
  end

  // Next-state logic
  always_comb begin
    tc_pkg::chan_s c;
    tc_pkg::chan_s n;
    logic [4:0]    nd;
    logic          nb;
    logic          moved;
    logic          showing;
    logic          dch;
    c       = '0;
    n       = '0;
    nd      = '0;
    nb      = 1'b0;
    moved   = 1'b0;
    showing = 1'b0;
    dch     = 1'b0;
    s_d     = s_q;
    // Base tick divider
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == 25'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 25'h1;
    end
    // Blink phase, rotation and show timeout
    if (s_q.tick) begin
      if (s_q.blink_cnt == 3'(`TC_BLINK_TICKS - 1)) begin
        s_d.blink_cnt = '0;
        s_d.blink     = ~s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 3'h1;
      end
      if (s_q.rot_cnt == 7'(`TC_ROT_TICKS - 1)) begin
        s_d.rot_cnt = '0;
        s_d.rot     = ~s_q.rot;
      end else begin
        s_d.rot_cnt = s_q.rot_cnt + 7'h1;
      end
      if (s_q.show_cnt != 5'h00) begin
        s_d.show_cnt = s_q.show_cnt - 5'h01;
      end
    end
    // Input synchronisers
    s_d.dial_s1 = dial_pos_i;
    s_d.dial_s2 = s_q.dial_s1;
    s_d.dial_s3 = s_q.dial_s2;
    s_d.btn_s1  = {second_channel_button_i, first_channel_button_i};
    s_d.btn_s2  = s_q.btn_s1;
    s_d.btn_s3  = s_q.btn_s2;
    // Channel control
    for (int i = 0; i < 2; i++) begin
      c     = s_q.ch[i];
      n     = c;
      nd    = (s_q.dial_s2[i] == s_q.dial_s3[i]) ? s_q.dial_s3[i] : c.dial;
      nb    = (s_q.btn_s2[i] == s_q.btn_s3[i]) ? s_q.btn_s3[i] : c.btn;
      moved = (nd != c.dial);
      n.dial = nd;
      n.btn  = nb;
      // Dial movement shows the setpoint for a while
      if (moved) begin
        n.idle       = 5'(`TC_SHOW_TICKS);
        s_d.show_cnt = 5'(`TC_SHOW_TICKS);
        s_d.show_ch  = 1'(i);
      end else if (s_q.tick && c.idle != 5'h00) begin
        n.idle = c.idle - 5'h01;
      end
      case (c.crv)
        tc_pkg::CRV_NORMAL: begin
          n.sp = dial_temp(nd);
        end
        tc_pkg::CRV_STOPPED: begin
          n.sp = curve_end_temp_i;
        end
        tc_pkg::CRV_RUN: begin
          // Hour timer and one-degree steps
          if (s_q.tick) begin
            if (c.hr_ticks == 16'(HOUR_TICKS - 1)) begin
              n.hr_ticks = '0;
              if (c.hrs + 7'h01 >= hours_per_degree_i) begin
                n.hrs = '0;
                if (c.sp - 8'sh01 <= curve_end_temp_i) begin
                  n.crv  = tc_pkg::CRV_STOPPED;
                  n.sp   = curve_end_temp_i;
                  n.capt = 1'b0;
                  n.pend = 1'b0;
                end else begin
                  n.sp = c.sp - 8'sh01;
                end
              end else begin
                n.hrs = c.hrs + 7'h01;
              end
            end else begin
              n.hr_ticks = c.hr_ticks + 16'h0001;
            end
          end
          // Dial takes over only after matching the setpoint
          if (!c.capt && nd != `TC_DIAL_OFF && dial_temp(nd) == c.sp) begin
            n.capt = 1'b1;
          end
          if (c.capt && moved) begin
            n.pend = 1'b1;
          end else if (c.pend && c.idle == 5'h00 && n.crv == tc_pkg::CRV_RUN) begin
            n.sp         = dial_temp(c.dial);
            n.pend       = 1'b0;
            s_d.show_cnt = '0;
          end
        end
        default: begin
          n.crv = tc_pkg::CRV_NORMAL;
        end
      endcase
      // Button hold timing and long press
      if (nb) begin
        if (s_q.tick && c.press != 6'h3f) begin
          n.press = c.press + 6'h01;
        end
        if (s_q.tick && !c.long_done && c.press == 6'(`TC_LONG_TICKS - 1)) begin
          n.long_done = 1'b1;
          n.hr_ticks  = '0;
          n.hrs       = '0;
          n.capt      = 1'b0;
          n.pend      = 1'b0;
          if (c.crv == tc_pkg::CRV_NORMAL) begin
            n.crv = tc_pkg::CRV_STOPPED;
            n.sp  = curve_end_temp_i;
          end else begin
            n.crv = tc_pkg::CRV_NORMAL;
            n.sp  = dial_temp(nd);
          end
        end
      end else begin
        n.press     = '0;
        n.long_done = 1'b0;
      end
      // Short press acts on release
      if (c.btn && !nb && !c.long_done && c.press < 6'(`TC_SHORT_TICKS)) begin
        s_d.show_cnt = 5'(`TC_SHOW_TICKS);
        s_d.show_ch  = 1'(i);
        if (c.crv == tc_pkg::CRV_STOPPED &&
            curve_start_temp_i > curve_end_temp_i) begin
          n.crv      = tc_pkg::CRV_RUN;
          n.sp       = curve_start_temp_i;
          n.hr_ticks = '0;
          n.hrs      = '0;
          n.capt     = 1'b0;
          n.pend     = 1'b0;
        end else if (c.crv == tc_pkg::CRV_RUN) begin
          n.crv  = tc_pkg::CRV_STOPPED;
          n.sp   = curve_end_temp_i;
          n.capt = 1'b0;
          n.pend = 1'b0;
        end
      end
      s_d.ch[i] = n;
    end
    // Display and indicator outputs
    showing     = (s_q.show_cnt != 5'h00);
    dch         = showing ? s_q.show_ch : s_q.rot;
    s_d.disp_ch = dch;
    if (showing) begin
      if (s_q.ch[dch].crv == tc_pkg::CRV_NORMAL && s_q.ch[dch].dial == `TC_DIAL_OFF) begin
        s_d.kind = tc_pkg::DISP_OFF;
      end else begin
        s_d.kind = tc_pkg::DISP_SETPT;
      end
      if (s_q.ch[dch].crv == tc_pkg::CRV_RUN && s_q.ch[dch].capt &&
          s_q.ch[dch].dial != `TC_DIAL_OFF) begin
        s_d.value = dial_temp(s_q.ch[dch].dial);
      end else begin
        s_d.value = s_q.ch[dch].sp;
      end
    end else if (fault[dch]) begin
      s_d.kind  = tc_pkg::DISP_ERR;
      s_d.value = actual[dch];
    end else if (!reg_en[dch]) begin
      s_d.kind  = tc_pkg::DISP_OFF;
      s_d.value = actual[dch];
    end else begin
      s_d.kind  = tc_pkg::DISP_ACTUAL;
      s_d.value = actual[dch];
    end
    case (s_q.ch[dch].crv)
      tc_pkg::CRV_STOPPED: s_d.dp = 1'b1;
      tc_pkg::CRV_RUN:     s_d.dp = s_q.blink;
      default:             s_d.dp = 1'b0;
    endcase
    s_d.green = showing ? s_q.blink : 1'b1;
    for (int j = 0; j < 2; j++) begin
      s_d.red[j]        = relay_o[j] | (showing && s_q.show_ch == 1'(j));
      s_d.chan_led[j]   = !showing && s_q.rot == 1'(j) && s_q.blink;
      s_d.curve_mode[j] = (s_q.ch[j].crv != tc_pkg::CRV_NORMAL);
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q          <= '0;
      s_q.ch[0].crv <= tc_pkg::CRV_NORMAL;
      s_q.ch[1].crv <= tc_pkg::CRV_NORMAL;
      s_q.kind     <= tc_pkg::DISP_ACTUAL;
    end else begin
      s_q <= s_d;
    end
  end

  // Registered outputs
  assign red_led_o    = s_q.red;
  assign chan_led_o   = s_q.chan_led;
  assign green_led_o  = s_q.green;
  assign curve_mode_o = s_q.curve_mode;
  assign disp_kind_o  = s_q.kind;
  assign disp_chan_o  = s_q.disp_ch;
  assign disp_value_o = s_q.value;
  assign disp_point_o = s_q.dp;

endmodule : thermostat_ctrl

// >>> verif/thermostat_ctrl_asserts.sv
// Purpose: Port checks for thermostat_ctrl
// Assumes: Bound from the bench, shortened tick
// Notes:   Bounds allow for the input synchronisers
`timescale 1ns/1ps
module thermostat_ctrl_asserts #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned HOUR_TICKS  = 3
) (
  // Clock, reset and panel
  input wire logic                sys_clk_i,
  input wire logic                rst_b_i,
  input wire logic                first_channel_button_i,
  input wire logic [1:0][4:0]     dial_pos_i,
  input wire tc_pkg::temp_t [1:0] sensor_temp_i,
  // Outputs
  input wire logic [1:0]          relay_o,
  input wire logic [1:0]          red_led_o,
  input wire logic                green_led_o,
  input wire logic [1:0]          curve_mode_o,
  input wire tc_pkg::disp_e       disp_kind_o,
  input wire tc_pkg::temp_t       disp_value_o,
  input wire logic                disp_point_o
);
  localparam int unsigned LONG_MIN = 48 * TICK_CYCLES;
  logic [15:0] hold_q;
  logic [4:0]  up_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Button hold length and cycles since reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q <= 16'h0000;
      up_q   <= 5'h00;
    end else begin
      hold_q <= first_channel_button_i ? hold_q + {15'h0000, ~&hold_q} : 16'h0000;
      up_q   <= up_q + {4'h0, ~&up_q};
    end
  end
  // Conditions held for eight cycles
  sequence hot_s;
    (sensor_temp_i[0] > 8'sh50) [*8];
  endsequence
  sequence cold_s;
    (sensor_temp_i[0] < -8'sh14) [*8];
  endsequence
  sequence off_s;
    (dial_pos_i[0] == 5'h00 && !curve_mode_o[0]) [*8];
  endsequence
  sequence calm_s;
    (up_q == 5'h1f && disp_kind_o == tc_pkg::DISP_ACTUAL) [*8];
  endsequence
  // Relay, LED and display relations
  hot_fault_a: assert property (hot_s |-> !relay_o[0])
    else $error("relay on with hot sensor");
  cold_fault_a: assert property (cold_s |-> !relay_o[0])
    else $error("relay on with cold sensor");
  dial_off_a: assert property (off_s |-> !relay_o[0])
    else $error("relay on with dial off");
  red_on_a: assert property ((relay_o[0]) [*2] |-> red_led_o[0])
    else $error("red dark with relay on");
  green_steady_a: assert property (calm_s |-> green_led_o)
    else $error("green not steady");
  long_hold_a: assert property ($changed(curve_mode_o[0]) |-> 32'(hold_q) >= LONG_MIN)
    else $error("mode changed without long hold");
  point_off_a: assert property ((curve_mode_o == 2'b00) [*3] |-> !disp_point_o)
    else $error("point lit in normal mode");
  setpt_range_a: assert property (
    disp_kind_o == tc_pkg::DISP_SETPT && curve_mode_o == 2'b00
      |-> disp_value_o inside {[8'sh14:8'sh32]})
    else $error("setpoint out of dial range");
endmodule : thermostat_ctrl_asserts

// >>> verif/panel_model.sv
// Purpose: Panel, dial and sensor model
// Assumes: Bench posts requests by non-blocking writes
// Notes:   Dial moves one code per cycle like a real knob
`timescale 1ns/1ps
module panel_model (
  // Clock and requests
  input  wire logic                sys_clk_i,
  input  wire logic [1:0]          btn_req_i,
  input  wire logic [1:0][4:0]     dial_req_i,
  input  wire tc_pkg::temp_t [1:0] temp_req_i,
  // Panel and sensor lines
  output logic [1:0]               btn_o,
  output logic [1:0][4:0]          dial_o,
  output tc_pkg::temp_t [1:0]      temp_o
);
  // Idle panel at time zero
  initial begin
    btn_o  = 2'b00;
    dial_o = '0;
    temp_o = '0;
  end
  // Lines change on the falling edge only
  always @(negedge sys_clk_i) begin
    btn_o  <= btn_req_i;
    temp_o <= temp_req_i;
    for (int i = 0; i < 2; i++) begin
      if (dial_o[i] < dial_req_i[i]) dial_o[i] <= dial_o[i] + 5'h01;
      else if (dial_o[i] > dial_req_i[i]) dial_o[i] <= dial_o[i] - 5'h01;
    end
  end
endmodule : panel_model

// >>> verif/dual_channel_thermostat_curve_ctrl_test.sv
// Purpose: Self-checking bench for thermostat_ctrl
// Assumes: Tick of 4 cycles, hour of 3 ticks
// Notes:   Dial code n gives n+19 degrees
`timescale 1ns/1ps
module dual_channel_thermostat_curve_ctrl_test;
  localparam int unsigned TICK_CYCLES = 4;
  localparam int unsigned HOUR_TICKS  = 3;
  logic                sys_clk_i = 1'b0;
  logic                rst_b_i   = 1'b0;
  logic [1:0]          btn_req   = 2'b00;
  logic [1:0][4:0]     dial_req  = '0;
  tc_pkg::temp_t [1:0] temp_req  = '0;
  tc_pkg::temp_t       crv_start = 8'sh19;
  tc_pkg::temp_t       crv_end   = 8'sh19;
  logic [6:0]          hpd       = 7'h14;
  logic [1:0]          btn;
  logic [1:0][4:0]     dial;
  tc_pkg::temp_t [1:0] temp;
  logic [1:0]          relay;
  logic [1:0]          red_led;
  logic [1:0]          chan_led;
  logic                green;
  logic [1:0]          curve_mode;
  tc_pkg::disp_e       disp_kind;
  logic                disp_chan;
  tc_pkg::temp_t       disp_value;
  logic                disp_point;
  int                  bad_count = 0;
  int                  checks_done = 0;
  int                  p0;
  int                  p1;
  // Clock
  always #2 sys_clk_i = ~sys_clk_i;
  // Far side and design
  panel_model u_panel (.sys_clk_i(sys_clk_i), .btn_req_i(btn_req), .dial_req_i(dial_req),
    .temp_req_i(temp_req), .btn_o(btn), .dial_o(dial), .temp_o(temp));
  thermostat_ctrl #(.TICK_CYCLES(TICK_CYCLES), .HOUR_TICKS(HOUR_TICKS)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .first_channel_button_i(btn[0]),
    .second_channel_button_i(btn[1]), .dial_pos_i(dial), .sensor_temp_i(temp),
    .curve_start_temp_i(crv_start), .curve_end_temp_i(crv_end), .hours_per_degree_i(hpd),
    .relay_o(relay), .red_led_o(red_led), .chan_led_o(chan_led), .green_led_o(green),
    .curve_mode_o(curve_mode), .disp_kind_o(disp_kind), .disp_chan_o(disp_chan),
    .disp_value_o(disp_value), .disp_point_o(disp_point));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp, input string msg);
    check_val({7'h00, got}, {7'h00, exp}, msg);
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : cyc
  task automatic wait_kind(input tc_pkg::disp_e k, input logic ch, input int lim);
    int n = 0;
    while (!(disp_kind === k && disp_chan === ch) && n < lim) begin
      cyc(1);
      n++;
    end
    check_bit(n < lim, 1'b1, "display wait ran out");
    if (n == lim) print_verdict();
  endtask : wait_kind
  task automatic set_ch(input int ch, input logic [4:0] d, input tc_pkg::temp_t t);
    dial_req[ch] <= d;
    temp_req[ch] <= t;
  endtask : set_ch
  task automatic press(input int ch, input int n);
    btn_req[ch] <= 1'b1;
    cyc(n);
    btn_req[ch] <= 1'b0;
    cyc(2);
  endtask : press
  // Counts point samples while channel 0 actual value is shown
  task automatic point_look(input int n, output int ones, output int zeros);
    ones = 0;
    zeros = 0;
    repeat (n) begin
      cyc(1);
      if (disp_chan === 1'b0 && disp_kind === tc_pkg::DISP_ACTUAL) begin
        if (disp_point === 1'b1) ones++;
        else zeros++;
      end
    end
  endtask : point_look
  // Hysteresis band around 30 degrees, channel 1 apart
  task automatic s_regulate();
    tc_pkg::temp_t t [6] = '{8'sh1c, 8'sh1d, 8'sh1e, 8'sh1f, 8'sh1d, 8'sh1c};
    logic e [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    int g = 0;
    set_ch(1, 5'h01, 8'sh15);
    for (int i = 0; i < 6; i++) begin
      set_ch(0, 5'h0b, t[i]);
      cyc(40);
      check_bit(relay[0], e[i], "relay ch0 band");
    end
    check_bit(relay[1], 1'b0, "relay ch1 apart");
    wait_kind(tc_pkg::DISP_ACTUAL, 1'b0, 800);
    check_bit(red_led[0], relay[0], "red follows relay");
    repeat (40) begin
      cyc(1);
      g += chan_led[0];
    end
    check_bit(g > 0 && g < 40, 1'b1, "channel led flashes");
    check_bit(chan_led[1], 1'b0, "other channel led dark");
  endtask : s_regulate
  // Sensor limits and dial off
  task automatic s_limits();
    set_ch(0, 5'h0b, -8'sh15);
    cyc(20);
    check_bit(relay[0], 1'b0, "relay cold fault");
    wait_kind(tc_pkg::DISP_ERR, 1'b0, 800);
    set_ch(0, 5'h0b, -8'sh14);
    cyc(20);
    check_bit(relay[0], 1'b1, "relay at low limit");
    set_ch(0, 5'h0b, 8'sh51);
    cyc(20);
    check_bit(relay[0], 1'b0, "relay hot fault");
    set_ch(0, 5'h00, 8'sh0a);
    cyc(40);
    check_bit(relay[0], 1'b0, "relay dial off");
    wait_kind(tc_pkg::DISP_OFF, 1'b0, 800);
  endtask : s_limits
  // Setpoint display by dial and by short press
  task automatic s_show();
    int g = 0;
    set_ch(0, 5'h1f, 8'sh37);
    cyc(40);
    wait_kind(tc_pkg::DISP_SETPT, 1'b0, 20);
    check_val(disp_value, 8'sh32, "dial top setpoint");
    repeat (60) begin
      cyc(1);
      g += green;
    end
    check_bit(g > 0 && g < 60, 1'b1, "green flashes");
    check_bit(red_led[0], 1'b1, "red steady on show");
    cyc(80);
    check_bit(disp_kind === tc_pkg::DISP_ACTUAL, 1'b1, "actual back");
    press(1, 20);
    wait_kind(tc_pkg::DISP_SETPT, 1'b1, 40);
    check_val(disp_value, 8'sh14, "dial low setpoint");
  endtask : s_show
  // Curve mode entry, refusal, start, stop, run to end, exit
  task automatic s_curve();
    set_ch(0, 5'h00, 8'sh17);
    press(0, 240);
    check_bit(curve_mode[0], 1'b1, "curve mode on");
    cyc(20);
    check_bit(relay[0], 1'b1, "end setpoint, dial off");
    set_ch(0, 5'h00, 8'sh1a);
    cyc(20);
    check_bit(relay[0], 1'b0, "above end setpoint");
    press(0, 20);
    point_look(400, p1, p0);
    check_bit(p0 == 0 && p1 > 0, 1'b1, "start refused");
    crv_start <= 8'sh1c;
    press(0, 20);
    point_look(20, p1, p0);
    check_bit(relay[0], 1'b1, "start setpoint");
    press(0, 20);
    cyc(20);
    check_bit(relay[0], 1'b0, "stop back to end");
    press(0, 20);
    point_look(400, p1, p0);
    check_bit(p0 > 0 && p1 > 0, 1'b1, "point flashes");
    cyc(200);
    check_bit(relay[0], 1'b1, "curve not too fast");
    cyc(160);
    check_bit(relay[0], 1'b0, "curve reached end");
    point_look(400, p1, p0);
    check_bit(p0 == 0 && p1 > 0, 1'b1, "stopped after end");
    press(0, 240);
    check_bit(curve_mode[0], 1'b0, "normal mode back");
  endtask : s_curve
  // Main sequence
  initial begin
    cyc(20);
    check_bit(curve_mode === 2'b00, 1'b1, "normal in reset");
    check_bit(disp_kind === tc_pkg::DISP_ACTUAL, 1'b1, "actual in reset");
    rst_b_i = 1'b1;
    cyc(10);
    s_regulate();
    s_limits();
    s_show();
    s_curve();
    print_verdict();
  end
endmodule : dual_channel_thermostat_curve_ctrl_test

bind thermostat_ctrl thermostat_ctrl_asserts #(
  .TICK_CYCLES(TICK_CYCLES), .HOUR_TICKS(HOUR_TICKS)) u_asserts (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .first_channel_button_i(first_channel_button_i),
  .dial_pos_i(dial_pos_i), .sensor_temp_i(sensor_temp_i), .relay_o(relay_o),
  .red_led_o(red_led_o), .green_led_o(green_led_o), .curve_mode_o(curve_mode_o),
  .disp_kind_o(disp_kind_o), .disp_value_o(disp_value_o), .disp_point_o(disp_point_o));
